// *** rtl/mce_pkg.sv ***
// Package for the machine check error logging block.
// Assumes one clock domain and software access through a register read port.
package mce_pkg;

   // ************************************************************
   // Bank numbers
   // ************************************************************
   localparam logic [4:0] MCE_BANK_PCU = 5'h04;
   localparam logic [4:0] MCE_BANK_MESH = 5'h0C;
   localparam logic [4:0] MCE_BANK_MC_FIRST = 5'h0D;
   localparam logic [4:0] MCE_BANK_MC_LAST = 5'h0F;
   localparam int MCE_NUM_MC = 3;

   // ************************************************************
   // Status register field layout
   // ************************************************************
   localparam int MCE_CODE_LSB = 0;
   localparam int MCE_CODE_MSB = 15;
   localparam int MCE_SUB_LSB = 16;
   localparam int MCE_SUB_MSB = 19;
   localparam int MCE_VALID_BIT = 63;
   localparam logic [63:0] MCE_STATUS_RESET = 64'h0000000000000000;
   localparam logic [63:0] MCE_MISC_RESET = 64'h0000000000000000;

   // ************************************************************
   // Code values
   // ************************************************************
   localparam logic [15:0] MCE_CODE_PCU = 16'h0402;
   localparam logic [15:0] MCE_CODE_FW = 16'h0406;
   localparam logic [15:0] MCE_CODE_UC_FW = 16'h040C;
   localparam logic [7:0] MCE_COMPOUND_TAG = 8'h80;
   localparam logic [3:0] MCE_SUB_MIN = 4'h1;
   localparam logic [3:0] MCE_SUB_MAX = 4'h7;

   // Source of a bank 4 report.
   typedef enum logic [1:0] {
      MCE_SRC_PCU = 2'h0,
      MCE_SRC_FW = 2'h1,
      MCE_SRC_UCFW = 2'h3
   } mce_src_type;

   // Builds a compound code 0000 0000 1MMM CCCC.
   function automatic logic [15:0] mce_compound(input logic [2:0] xact,
                                                input logic [3:0] chan);
      mce_compound = {8'h00, MCE_COMPOUND_TAG | {1'b0, xact, chan}};
   endfunction

   // Tells whether a subcode is one of the defined ones.
   function automatic logic mce_sub_ok(input logic [3:0] sub);
      mce_sub_ok = (sub >= MCE_SUB_MIN) && (sub <= MCE_SUB_MAX);
   endfunction

endpackage

// *** rtl/mce_bank.sv ***
// One machine check bank: a status register and optional misc register.
// Assumes the caller presents a complete status word with its valid bit.
`timescale 1ns/1ps
module mce_bank
   import mce_pkg::*;
(
   input wire logic mclk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic log_stb, // One-cycle request to log.
   input wire logic [63:0] log_status, // Status word to log.
   input wire logic [63:0] log_misc, // Misc word to log.
   input wire logic clr_stb, // Software clear of the valid flag.
   output logic [63:0] status_reg, // Stored status word.
   output logic [63:0] misc_reg // Stored misc word.
);

   // ************************************************************
   // Storage
   // ************************************************************
   // A new log is taken only while the bank is free, which keeps the
   // first error visible; a log arriving on a clear wins over it.
   wire logic bank_valid = status_reg[MCE_VALID_BIT];
   wire logic take = log_stb && (!bank_valid || clr_stb);

   // Status and misc load together on a log so they describe one event; a clear resets only status.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= MCE_STATUS_RESET;
         misc_reg <= MCE_MISC_RESET;
      end else if (take) begin
         status_reg <= log_status;
         misc_reg <= log_misc;
      end else if (clr_stb) begin
         status_reg <= MCE_STATUS_RESET;
      end
   end

   chk_hold_while_valid: assert property (@(posedge mclk) disable iff (!rst_n)
      bank_valid && !clr_stb |=> status_reg == $past(status_reg))
      else $error("bank overwritten while valid");

endmodule

// *** rtl/mce_pcu_code.sv ***
// Builds the bank 4 status word from a power control unit report.
// Assumes same-clock inputs; output is registered one cycle later.
`timescale 1ns/1ps
module mce_pcu_code
   import mce_pkg::*;
(
   input wire logic mclk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic in_stb, // One-cycle report.
   input wire mce_src_type in_src, // Report source.
   input wire logic [3:0] in_sub, // Fault subcode.
   output logic out_stb, // Word ready, one cycle.
   output logic [63:0] out_status // Bank 4 status word.
);

   // ************************************************************
   // Code selection
   // ************************************************************
   // The internal code follows the source; microcontroller firmware
   // faults use the 40Ch form whose subcode means the same seven faults.
   wire logic [15:0] code_sel = (in_src == MCE_SRC_PCU) ? MCE_CODE_PCU :
                               (in_src == MCE_SRC_FW) ? MCE_CODE_FW :
                               MCE_CODE_UC_FW;
   // Undefined subcodes are never produced: the report is dropped.
   wire logic sub_ok = mce_sub_ok(in_sub);
   wire logic [63:0] word = {1'b1, 43'h0, in_sub, code_sel};

   // Registers the word with its valid flag set.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_stb <= 1'b0;
         out_status <= MCE_STATUS_RESET;
      end else begin
         out_stb <= in_stb && sub_ok;
         out_status <= word;
      end
   end

   chk_sub_defined: assert property (@(posedge mclk) disable iff (!rst_n)
      out_stb |-> mce_sub_ok(out_status[MCE_SUB_MSB:MCE_SUB_LSB]))
      else $error("reserved subcode produced");

endmodule

// *** rtl/mce_log.sv ***
// Machine check error logging: banks 4, 12 and 13 to 15.
// Assumes reporters give one-cycle strobes on mclk and software reads
// the banks through the model-specific register read port below.
`timescale 1ns/1ps
module mce_log
   import mce_pkg::*;
(
   input wire logic mclk, // System clock, 200 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic mc_err_stb, // Memory controller error pulse.
   input wire logic [1:0] mc_err_ctrl, // Controller index 0 to 2.
   input wire logic [2:0] mc_err_xact, // Transaction field.
   input wire logic [3:0] mc_err_chan, // Channel field.
   input wire logic [63:0] mc_err_corr, // Correction details.
   input wire logic mesh_err_stb, // Mesh agent error pulse.
   input wire logic [2:0] mesh_err_xact, // Transaction field.
   input wire logic [3:0] mesh_err_chan, // Channel field.
   input wire logic pcu_err_stb, // Power control error pulse.
   input wire mce_src_type pcu_err_src, // Source of the error.
   input wire logic [3:0] pcu_err_sub, // Fault subcode.
   input wire logic msr_rd, // Register read pulse.
   input wire logic msr_clr, // Clear valid flag of a bank.
   input wire logic [4:0] msr_bank, // Bank number.
   input wire logic msr_misc, // Select misc instead of status.
   output logic msr_rvalid, // Read data valid, one cycle.
   output logic [63:0] msr_rdata // Read data.
);

   // ************************************************************
   // Memory controller banks
   // ************************************************************
   // Each controller lands in its own bank, 13 plus its index.
   wire logic [15:0] mc_code = mce_compound(mc_err_xact, mc_err_chan);
   wire logic [63:0] mc_word = {1'b1, 47'h0, mc_code};
   wire logic [MCE_NUM_MC-1:0] mc_hit;
   wire logic [MCE_NUM_MC-1:0] mc_clr;
   logic [63:0] mc_status [MCE_NUM_MC];
   logic [63:0] mc_misc [MCE_NUM_MC];

   for (genvar i = 0; i < MCE_NUM_MC; i++) begin : g_mc
      assign mc_hit[i] = mc_err_stb && (mc_err_ctrl == 2'(i));
      assign mc_clr[i] = msr_clr &&
         (msr_bank == MCE_BANK_MC_FIRST + 5'(i));
      mce_bank u_bank (
         .mclk(mclk),
         .rst_n(rst_n),
         .log_stb(mc_hit[i]),
         .log_status(mc_word),
         .log_misc(mc_err_corr),
         .clr_stb(mc_clr[i]),
         .status_reg(mc_status[i]),
         .misc_reg(mc_misc[i])
      );
   end

   // ************************************************************
   // Mesh agent bank
   // ************************************************************
   wire logic [15:0] mesh_code = mce_compound(mesh_err_xact, mesh_err_chan);
   wire logic [63:0] mesh_word = {1'b1, 47'h0, mesh_code};
   wire logic mesh_clr = msr_clr && (msr_bank == MCE_BANK_MESH);
   logic [63:0] mesh_status;

   mce_bank u_mesh (
      .mclk(mclk),
      .rst_n(rst_n),
      .log_stb(mesh_err_stb),
      .log_status(mesh_word),
      .log_misc(MCE_MISC_RESET),
      .clr_stb(mesh_clr),
      .status_reg(mesh_status),
      .misc_reg()
   );

   // ************************************************************
   // Power control bank
   // ************************************************************
   logic pcu_stb;
   logic [63:0] pcu_word;
   logic [63:0] pcu_status;
   wire logic pcu_clr = msr_clr && (msr_bank == MCE_BANK_PCU);

   mce_pcu_code u_code (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_stb(pcu_err_stb),
      .in_src(pcu_err_src),
      .in_sub(pcu_err_sub),
      .out_stb(pcu_stb),
      .out_status(pcu_word)
   );

   mce_bank u_pcu (
      .mclk(mclk),
      .rst_n(rst_n),
      .log_stb(pcu_stb),
      .log_status(pcu_word),
      .log_misc(MCE_MISC_RESET),
      .clr_stb(pcu_clr),
      .status_reg(pcu_status),
      .misc_reg()
   );

   // ************************************************************
   // Read port
   // ************************************************************
   // Unknown banks and misc of banks without one read as zero.
   wire logic is_mc = (msr_bank >= MCE_BANK_MC_FIRST) &&
                      (msr_bank <= MCE_BANK_MC_LAST);
   wire logic [1:0] mc_idx = 2'(msr_bank - MCE_BANK_MC_FIRST);
   wire logic [63:0] mc_rd = msr_misc ? mc_misc[mc_idx] : mc_status[mc_idx];
   wire logic [63:0] rd_sel =
      is_mc ? mc_rd :
      (msr_misc) ? 64'h0000000000000000 :
      (msr_bank == MCE_BANK_MESH) ? mesh_status :
      (msr_bank == MCE_BANK_PCU) ? pcu_status :
      64'h0000000000000000;

   // Registers read data so the outputs come from flip-flops.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         msr_rvalid <= 1'b0;
         msr_rdata <= 64'h0000000000000000;
      end else begin
         msr_rvalid <= msr_rd;
         msr_rdata <= msr_rd ? rd_sel : 64'h0000000000000000;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_mc_err(int k);
      mc_err_stb && mc_err_ctrl == 2'(k) && !mc_status[k][MCE_VALID_BIT]
         && !mc_clr[k];
   endsequence

   chk_mc_bank_log: assert property (@(posedge mclk) disable iff (!rst_n)
      s_mc_err(0) |=> mc_status[0][MCE_VALID_BIT] && mc_status[0][7])
      else $error("controller error not logged in bank 13");

   chk_mc_misc_corr: assert property (@(posedge mclk) disable iff (!rst_n)
      s_mc_err(1) |=> mc_misc[1] == $past(mc_err_corr))
      else $error("correction details missing");

   chk_mesh_code: assert property (@(posedge mclk) disable iff (!rst_n)
      mesh_status[MCE_VALID_BIT] |-> mesh_status[15:7] == 9'h001)
      else $error("mesh code not compound");

   chk_mesh_log: assert property (@(posedge mclk) disable iff (!rst_n)
      mesh_err_stb && !mesh_status[MCE_VALID_BIT] && !mesh_clr
      |=> mesh_status[6:0] == $past({mesh_err_xact, mesh_err_chan}))
      else $error("mesh error not in bank 12");

   chk_pcu_code: assert property (@(posedge mclk) disable iff (!rst_n)
      pcu_status[MCE_VALID_BIT] |-> pcu_status[15:0] == MCE_CODE_PCU ||
      pcu_status[15:0] == MCE_CODE_FW || pcu_status[15:0] == MCE_CODE_UC_FW)
      else $error("bank 4 code wrong");

   chk_pcu_log: assert property (@(posedge mclk) disable iff (!rst_n)
      pcu_err_stb && pcu_err_src == MCE_SRC_PCU && mce_sub_ok(pcu_err_sub)
      && !pcu_status[MCE_VALID_BIT] && !pcu_clr
      ##1 !pcu_clr |=> pcu_status[15:0] == MCE_CODE_PCU)
      else $error("power control error not in bank 4");

   chk_pcu_sub: assert property (@(posedge mclk) disable iff (!rst_n)
      pcu_status[MCE_VALID_BIT] |->
      mce_sub_ok(pcu_status[MCE_SUB_MSB:MCE_SUB_LSB]))
      else $error("bank 4 subcode out of range");

   chk_read_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      pcu_clr && !pcu_stb |=> !pcu_status[MCE_VALID_BIT])
      else $error("valid flag not cleared");

endmodule

// *** bench/mce_log_tb.sv ***
// Self-checking testbench for the machine check error logging block.
// Assumes the design package and mce_log are compiled before this file.
`timescale 1ns/1ps
module mce_log_tb
   import mce_pkg::*;
;
   // ************************************************************
   // Stimulus signals and counters
   // ************************************************************
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic mc_err_stb = 1'b0;
   logic [1:0] mc_err_ctrl = 2'h0;
   logic [2:0] mc_err_xact = 3'h0;
   logic [3:0] mc_err_chan = 4'h0;
   logic [63:0] mc_err_corr = 64'h0;
   logic mesh_err_stb = 1'b0;
   logic [2:0] mesh_err_xact = 3'h0;
   logic [3:0] mesh_err_chan = 4'h0;
   logic pcu_err_stb = 1'b0;
   mce_src_type pcu_err_src = MCE_SRC_PCU;
   logic [3:0] pcu_err_sub = 4'h0;
   logic msr_rd = 1'b0;
   logic msr_clr = 1'b0;
   logic [4:0] msr_bank = 5'h00;
   logic msr_misc = 1'b0;
   logic msr_rvalid;
   logic [63:0] msr_rdata;
   int err_count = 0;
   int check_count = 0;
   logic [15:0] pc_code [3] = '{16'h0402, 16'h0406, 16'h040C};
   mce_src_type pc_src [3] = '{MCE_SRC_PCU, MCE_SRC_FW, MCE_SRC_UCFW};

   // The clock toggles every half period of 2.5 ns.
   always #2.5 mclk = ~mclk;

   mce_log dut (.mclk(mclk), .rst_n(rst_n), .mc_err_stb(mc_err_stb),
      .mc_err_ctrl(mc_err_ctrl), .mc_err_xact(mc_err_xact),
      .mc_err_chan(mc_err_chan), .mc_err_corr(mc_err_corr),
      .mesh_err_stb(mesh_err_stb), .mesh_err_xact(mesh_err_xact),
      .mesh_err_chan(mesh_err_chan), .pcu_err_stb(pcu_err_stb),
      .pcu_err_src(pcu_err_src), .pcu_err_sub(pcu_err_sub),
      .msr_rd(msr_rd), .msr_clr(msr_clr), .msr_bank(msr_bank),
      .msr_misc(msr_misc), .msr_rvalid(msr_rvalid),
      .msr_rdata(msr_rdata));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Compares a seen value with the expected one and counts both.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Reads one register and compares its data one edge later.
   task automatic rd(input logic [4:0] b, input logic m,
                     input logic [63:0] exp);
      @(posedge mclk);
      msr_rd <= 1'b1;
      msr_bank <= b;
      msr_misc <= m;
      @(posedge mclk);
      msr_rd <= 1'b0;
      #1;
      check({63'h0, msr_rvalid}, 64'h1);
      check(msr_rdata, exp);
   endtask

   // Clears the status word of one bank.
   task automatic clr(input logic [4:0] b);
      @(posedge mclk);
      msr_clr <= 1'b1;
      msr_bank <= b;
      @(posedge mclk);
      msr_clr <= 1'b0;
   endtask

   // Raises one memory controller error report.
   task automatic mc_err(input logic [1:0] c, input logic [2:0] x,
                         input logic [3:0] h, input logic [63:0] cr);
      @(posedge mclk);
      mc_err_stb <= 1'b1;
      mc_err_ctrl <= c;
      mc_err_xact <= x;
      mc_err_chan <= h;
      mc_err_corr <= cr;
      @(posedge mclk);
      mc_err_stb <= 1'b0;
   endtask

   // Raises one power control report and waits for bank 4 to update.
   task automatic pcu_err(input mce_src_type s, input logic [3:0] sb);
      @(posedge mclk);
      pcu_err_stb <= 1'b1;
      pcu_err_src <= s;
      pcu_err_sub <= sb;
      @(posedge mclk);
      pcu_err_stb <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ************************************************************
   // Test sequence
   // ************************************************************
   // Runs every test in order after five cycles of reset.
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      rd(5'h0D, 1'b0, 64'h0);
      rd(5'h04, 1'b0, 64'h0);
      $display("Test reset values done");
      for (int i = 0; i < 3; i++) begin
         mc_err(i[1:0], 3'(i + 5), 4'(i + 9), 64'hA5A5_0000_0000_0000 + i);
      end
      rd(5'h0C, 1'b0, 64'h0);
      for (int i = 0; i < 3; i++) begin
         rd(5'h0D + 5'(i), 1'b0, {1'b1, 55'h0, 1'b1, 3'(i + 5),
            4'(i + 9)});
         rd(5'h0D + 5'(i), 1'b1, 64'hA5A5_0000_0000_0000 + i);
      end
      mc_err(2'h0, 3'h1, 4'h2, 64'h0);
      rd(5'h0D, 1'b0, {1'b1, 55'h0, 8'hD9});
      clr(5'h0D);
      rd(5'h0D, 1'b0, 64'h0);
      mc_err(2'h3, 3'h2, 4'h3, 64'h1);
      rd(5'h0D, 1'b0, 64'h0);
      check({63'h0, msr_rvalid}, 64'h1);
      @(posedge mclk);
      #1;
      check({63'h0, msr_rvalid}, 64'h0);
      check(msr_rdata, 64'h0);
      $display("Test memory controller banks done");
      @(posedge mclk);
      mesh_err_stb <= 1'b1;
      mesh_err_xact <= 3'h7;
      mesh_err_chan <= 4'hF;
      @(posedge mclk);
      mesh_err_stb <= 1'b0;
      rd(5'h0C, 1'b0, {1'b1, 55'h0, 8'hFF});
      rd(5'h0C, 1'b1, 64'h0);
      clr(5'h0C);
      $display("Test mesh bank done");
      for (int s = 0; s < 3; s++) begin
         for (int k = 1; k < 8; k++) begin
            pcu_err(pc_src[s], 4'(k));
            rd(5'h04, 1'b0, {1'b1, 43'h0, 4'(k), pc_code[s]});
            clr(5'h04);
         end
      end
      pcu_err(MCE_SRC_PCU, 4'h0);
      rd(5'h04, 1'b0, 64'h0);
      pcu_err(MCE_SRC_FW, 4'h8);
      rd(5'h04, 1'b0, 64'h0);
      rd(5'h1F, 1'b0, 64'h0);
      $display("Test power control bank done");
      tally_and_finish();
   end

   // Cuts a hang short well after the tests should have ended.
   initial begin
      #20000;
      err_count++;
      tally_and_finish();
   end
endmodule
